//--- core/ebdram_pin.sv
// output and enable selection for one group of shared bus pins
`timescale 1ns/1ps
module ebdram_pin #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ext_mode,
  input  wire logic             hold_act,
  input  wire logic [WIDTH-1:0] keep_mask,
  input  wire logic [WIDTH-1:0] port_val,
  input  wire logic [WIDTH-1:0] port_dir,
  input  wire logic [WIDTH-1:0] bus_val,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe
);
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out <= '0;
    end else if (ext_mode) begin
      pin_out <= bus_val;
    end else begin
      pin_out <= port_val;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_oe <= '0;
    end else if (!ext_mode) begin
      pin_oe <= port_dir;
    end else if (hold_act) begin
      pin_oe <= keep_mask;
    end else begin
      pin_oe <= '1;
    end
  end

  AST_HOLD_KEEP: assert property (@(posedge clk) disable iff (rst)
    (ext_mode && hold_act) |=> ((pin_oe & $past(keep_mask)) == $past(keep_mask)))
    else $error("kept pin released under hold");

  AST_SC_PORT: assert property (@(posedge clk) disable iff (rst)
    !ext_mode |=> (pin_out == $past(port_val) && pin_oe == $past(port_dir)))
    else $error("single-chip pin not driving port value");
endmodule

//--- core/ebdram_pkg.sv
// constants and types of the external bus and dram control block
// How it works
// - control value 01h gives dram ignored with one wait state
// - control value 0Bh gives 4 MB dram space with one wait state
// - pins left as outputs from single-chip mode stay driven under hold
// - bus pins keep their last level through wait and stop
// - port writes ignored in bus modes; single-chip drives port values
// - boot-mode pin high at reset blocks internal rom readout
package ebdram_pkg;
  localparam logic [3:0] OFF_DRAM_CTL   = 4'h0;
  localparam logic [3:0] OFF_PROC_MODE0 = 4'h1;
  localparam logic [3:0] OFF_WPROT      = 4'h2;
  localparam logic [3:0] OFF_P4_DATA    = 4'h3;
  localparam logic [3:0] OFF_P4_DIR     = 4'h4;
  localparam logic [3:0] OFF_P5_DATA    = 4'h5;
  localparam logic [3:0] OFF_P5_DIR     = 4'h6;
  localparam logic [3:0] OFF_LOW_POWER  = 4'h7;
  localparam logic [3:0] OFF_STATUS     = 4'h8;

  localparam int WAIT_BIT    = 0;
  localparam int SPACE_LSB   = 1;
  localparam int SPACE_MSB   = 3;
  localparam int SR_BIT      = 7;
  localparam logic [2:0] SPACE_IGNORED = 3'h0;
  localparam logic [2:0] SPACE_4MB     = 3'h5;
  localparam int SPACE_ADDR_BASE = 17;
  localparam logic [7:0] CTL_IGNORE_1W = 8'h01;
  localparam logic [7:0] CTL_4MB_1W    = 8'h0B;

  localparam int MODE_LSB  = 0;
  localparam int MODE_MSB  = 1;
  localparam int SWRST_BIT = 3;
  localparam int WP_PM_BIT = 1;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_MEMEXP = 2'h1;
  localparam logic [1:0] MODE_MICRO  = 2'h3;

  localparam int LP_WAIT_BIT = 0;
  localparam int LP_STOP_BIT = 1;

  localparam int ST_SR      = 0;
  localparam int ST_BLOCK   = 1;
  localparam int ST_SEQERR  = 2;
  localparam int ST_ROMLOCK = 3;
  localparam int ST_LP      = 4;

  localparam logic [7:0] RST_DRAM_CTL = 8'h00;
  localparam logic [7:0] RST_WPROT    = 8'h00;
  localparam logic [7:0] RST_PORT     = 8'h00;
  localparam logic [1:0] RST_LP       = 2'h0;
  localparam logic [2:0] STROBE_IDLE  = 3'h7;

  localparam int SPACE_SETTLE_CYCLES = 1;

  typedef enum logic [1:0] {SR_IDLE, SR_ARMED, SR_ACTIVE, SR_LEAVING} ebdram_sr_t;
endpackage

//--- core/ebdram_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ebdram_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    meta <= d;
    q    <= meta;
  end
endmodule

//--- core/ebdram_top.sv
// external bus, dram self-refresh and pin control
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
module ebdram_top #(
  parameter int ADDR_W = 24
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RESET,
  input  wire logic [3:0]        REG_ADDR,
  input  wire logic [7:0]        REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic      [7:0]        REG_RDATA,
  input  wire logic              BUS_REQ,
  input  wire logic              BUS_WE,
  input  wire logic [ADDR_W-1:0] BUS_ADDR,
  output logic                   BUS_GRANT,
  output logic                   BUS_DRAM_SEL,
  input  wire logic              WAKE,
  input  wire logic              HOLD_N,
  input  wire logic              BOOT_MODE_PIN,
  input  wire logic              ROM_RD_REQ,
  output logic                   ROM_RD_GRANT,
  output logic      [2:0]        DRAM_SPACE,
  output logic                   DRAM_WAIT,
  output logic                   SELF_REFRESH,
  output logic                   SW_RESET,
  output logic                   LOW_POWER,
  input  wire logic [7:0]        P4_IN,
  output logic      [7:0]        P4_OUT,
  output logic      [7:0]        P4_OE,
  input  wire logic [2:0]        P5_IN,
  output logic      [2:0]        P5_OUT,
  output logic      [2:0]        P5_OE
);
  logic [7:0]  dram_ctl_word;
  logic [1:0]  proc_mode;
  logic [7:0]  write_protect_reg;
  logic [7:0]  p4_data;
  logic [7:0]  p4_dir;
  logic [2:0]  p5_data;
  logic [2:0]  p5_dir;
  logic [7:0]  p4_keep;
  logic [2:0]  p5_keep;
  logic [7:0]  p4_bus;
  logic [2:0]  p5_bus;
  logic [1:0]  lp_ctl;
  logic        sw_rst;
  logic        rom_lock;
  logic        seq_err;
  logic [1:0]  settle;
  logic [12:0] pin_sync;
  logic        hold_n_s;
  logic        boot_s;
  logic [7:0]  p4_in_s;
  logic [2:0]  p5_in_s;
  logic        rst_all;
  logic        ext_mode;
  logic        hold_act;
  logic        lp_active;
  logic        dram_hit;
  logic        dram_block;
  logic        wr_dram;
  logic [2:0]  w_space;
  ebdram_pkg::ebdram_sr_t sr_state;
  ebdram_pkg::ebdram_sr_t next_sr_state;
  logic        next_seq_err;

  // true when the address falls in the dram area at the top of the space
  function automatic logic in_dram(input logic [ADDR_W-1:0] a, input logic [2:0] sp);
    int bits;
    logic hit;
    bits = int'(sp) + ebdram_pkg::SPACE_ADDR_BASE;
    hit  = (sp != ebdram_pkg::SPACE_IGNORED);
    for (int i = 0; i < ADDR_W; i++) begin
      if (i >= bits && !a[i]) begin
        hit = 1'b0;
      end
    end
    return hit;
  endfunction

  ebdram_sync #(.WIDTH(13)) u_sync (
    .clk (SYS_CLK),
    .d   ({BOOT_MODE_PIN, HOLD_N, P5_IN, P4_IN}),
    .q   (pin_sync)
  );

  assign boot_s    = pin_sync[12];
  assign hold_n_s  = pin_sync[11];
  assign p5_in_s   = pin_sync[10:8];
  assign p4_in_s   = pin_sync[7:0];
  assign rst_all   = RESET || sw_rst;
  assign ext_mode  = (proc_mode != ebdram_pkg::MODE_SINGLE);
  assign hold_act  = ext_mode && !hold_n_s;
  assign lp_active = (lp_ctl != 2'h0);
  assign wr_dram   = REG_WR && (REG_ADDR == ebdram_pkg::OFF_DRAM_CTL);
  assign w_space   = REG_WDATA[ebdram_pkg::SPACE_MSB:ebdram_pkg::SPACE_LSB];
  assign dram_block = (settle != 2'h0);

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rom_lock <= boot_s;
    end
  end

  assign ROM_RD_GRANT = ROM_RD_REQ && !rom_lock;

  always_ff @(posedge SYS_CLK) begin
    if (rst_all) begin
      dram_ctl_word <= ebdram_pkg::RST_DRAM_CTL;
    end else if (wr_dram) begin
      dram_ctl_word <= REG_WDATA;
    end
  end

  assign DRAM_SPACE   = dram_ctl_word[ebdram_pkg::SPACE_MSB:ebdram_pkg::SPACE_LSB];
  assign DRAM_WAIT    = dram_ctl_word[ebdram_pkg::WAIT_BIT];
  assign SELF_REFRESH = dram_ctl_word[ebdram_pkg::SR_BIT];

  always_comb begin
    next_sr_state = sr_state;
    next_seq_err  = 1'b0;
    if (wr_dram) begin
      if (REG_WDATA[ebdram_pkg::SR_BIT]) begin
        next_sr_state = ebdram_pkg::SR_ACTIVE;
        next_seq_err  = (sr_state != ebdram_pkg::SR_ARMED);
      end else if (w_space == ebdram_pkg::SPACE_IGNORED) begin
        next_sr_state = (sr_state == ebdram_pkg::SR_ACTIVE) ? ebdram_pkg::SR_LEAVING
                                                            : ebdram_pkg::SR_ARMED;
      end else begin
        next_sr_state = ebdram_pkg::SR_IDLE;
        next_seq_err  = (sr_state == ebdram_pkg::SR_ACTIVE);
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (rst_all) begin
      sr_state <= ebdram_pkg::SR_IDLE;
    end else begin
      case (sr_state)
        ebdram_pkg::SR_IDLE, ebdram_pkg::SR_ARMED,
        ebdram_pkg::SR_ACTIVE, ebdram_pkg::SR_LEAVING: sr_state <= next_sr_state;
        default: sr_state <= ebdram_pkg::SR_IDLE;
      endcase
    end
  end

  // sticky error, set wins over clear
  always_ff @(posedge SYS_CLK) begin
    if (rst_all) begin
      seq_err <= 1'b0;
    end else if (next_seq_err) begin
      seq_err <= 1'b1;
    end else if (REG_WR && REG_ADDR == ebdram_pkg::OFF_STATUS
                 && REG_WDATA[ebdram_pkg::ST_SEQERR]) begin
      seq_err <= 1'b0;
    end
  end

  // dram area held off after space write
  always_ff @(posedge SYS_CLK) begin
    if (rst_all) begin
      settle <= 2'h0;
    end else if (wr_dram && w_space != ebdram_pkg::SPACE_IGNORED) begin
      settle <= 2'(ebdram_pkg::SPACE_SETTLE_CYCLES);
    end else if (settle != 2'h0) begin
      settle <= settle - 2'h1;
    end
  end

  // processor mode and software reset
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      proc_mode <= ebdram_pkg::MODE_SINGLE;
      sw_rst    <= 1'b0;
    end else if (sw_rst) begin
      proc_mode <= rom_lock ? ebdram_pkg::MODE_MICRO : ebdram_pkg::MODE_SINGLE;
      sw_rst    <= 1'b0;
    end else if (REG_WR && REG_ADDR == ebdram_pkg::OFF_PROC_MODE0
                 && write_protect_reg[ebdram_pkg::WP_PM_BIT]) begin
      proc_mode <= REG_WDATA[ebdram_pkg::MODE_MSB:ebdram_pkg::MODE_LSB];
      sw_rst    <= REG_WDATA[ebdram_pkg::SWRST_BIT];
    end else if (proc_mode == ebdram_pkg::MODE_SINGLE && rom_lock
                 && $past(RESET)) begin
      proc_mode <= ebdram_pkg::MODE_MICRO;
    end
  end

  assign SW_RESET = sw_rst;

  always_ff @(posedge SYS_CLK) begin
    if (rst_all) begin
      write_protect_reg <= ebdram_pkg::RST_WPROT;
    end else if (REG_WR && REG_ADDR == ebdram_pkg::OFF_WPROT) begin
      write_protect_reg <= REG_WDATA;
    end
  end

  // port writes ignored in bus modes
  always_ff @(posedge SYS_CLK) begin
    if (rst_all) begin
      p4_data <= ebdram_pkg::RST_PORT;
      p4_dir  <= ebdram_pkg::RST_PORT;
      p5_data <= ebdram_pkg::RST_PORT[2:0];
      p5_dir  <= ebdram_pkg::RST_PORT[2:0];
    end else if (REG_WR && !ext_mode) begin
      case (REG_ADDR)
        ebdram_pkg::OFF_P4_DATA: p4_data <= REG_WDATA;
        ebdram_pkg::OFF_P4_DIR:  p4_dir  <= REG_WDATA;
        ebdram_pkg::OFF_P5_DATA: p5_data <= REG_WDATA[2:0];
        ebdram_pkg::OFF_P5_DIR:  p5_dir  <= REG_WDATA[2:0];
        default: p4_data <= p4_data;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (rst_all || !ext_mode) begin
      p4_keep <= p4_dir;
      p5_keep <= p5_dir;
    end
  end

  // low-power request, left on wake
  always_ff @(posedge SYS_CLK) begin
    if (rst_all || WAKE) begin
      lp_ctl <= ebdram_pkg::RST_LP;
    end else if (REG_WR && REG_ADDR == ebdram_pkg::OFF_LOW_POWER) begin
      lp_ctl <= REG_WDATA[ebdram_pkg::LP_STOP_BIT:ebdram_pkg::LP_WAIT_BIT];
    end
  end

  assign LOW_POWER = lp_active;

  assign dram_hit  = in_dram(BUS_ADDR, DRAM_SPACE);
  assign BUS_GRANT = BUS_REQ && ext_mode && !SELF_REFRESH && !lp_active
                     && !hold_act && !(dram_block && dram_hit);
  assign BUS_DRAM_SEL = BUS_GRANT && in_dram(BUS_ADDR, DRAM_SPACE);

  // bus levels frozen in low power
  always_ff @(posedge SYS_CLK) begin
    if (rst_all) begin
      p4_bus <= 8'h00;
      p5_bus <= ebdram_pkg::STROBE_IDLE;
    end else if (!lp_active) begin
      if (BUS_GRANT) begin
        p4_bus <= BUS_ADDR[ADDR_W-1:ADDR_W-8];
        p5_bus <= {!dram_hit, !BUS_WE, BUS_WE};
      end else begin
        p5_bus <= ebdram_pkg::STROBE_IDLE;
      end
    end
  end

  ebdram_pin #(.WIDTH(8)) u_p4 (
    .clk       (SYS_CLK),
    .rst       (rst_all),
    .ext_mode  (ext_mode),
    .hold_act  (hold_act),
    .keep_mask (p4_keep),
    .port_val  (p4_data),
    .port_dir  (p4_dir),
    .bus_val   (p4_bus),
    .pin_out   (P4_OUT),
    .pin_oe    (P4_OE)
  );

  ebdram_pin #(.WIDTH(3)) u_p5 (
    .clk       (SYS_CLK),
    .rst       (rst_all),
    .ext_mode  (ext_mode),
    .hold_act  (hold_act),
    .keep_mask (p5_keep),
    .port_val  (p5_data),
    .port_dir  (p5_dir),
    .bus_val   (p5_bus),
    .pin_out   (P5_OUT),
    .pin_oe    (P5_OE)
  );

  // register read, data one cycle later
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        ebdram_pkg::OFF_DRAM_CTL:   REG_RDATA <= dram_ctl_word;
        ebdram_pkg::OFF_PROC_MODE0: REG_RDATA <= {6'h00, proc_mode};
        ebdram_pkg::OFF_WPROT:      REG_RDATA <= write_protect_reg;
        ebdram_pkg::OFF_P4_DATA:    REG_RDATA <= (p4_data & p4_dir) | (p4_in_s & ~p4_dir);
        ebdram_pkg::OFF_P4_DIR:     REG_RDATA <= p4_dir;
        ebdram_pkg::OFF_P5_DATA:    REG_RDATA <= {5'h00, (p5_data & p5_dir) | (p5_in_s & ~p5_dir)};
        ebdram_pkg::OFF_P5_DIR:     REG_RDATA <= {5'h00, p5_dir};
        ebdram_pkg::OFF_LOW_POWER:  REG_RDATA <= {6'h00, lp_ctl};
        ebdram_pkg::OFF_STATUS:     REG_RDATA <= {3'h0, lp_active, rom_lock, seq_err,
                                                  dram_block, sr_state == ebdram_pkg::SR_ACTIVE};
        default:                    REG_RDATA <= 8'h00;
      endcase
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  AST_CTL_IGNORE: assert property (@(posedge SYS_CLK) disable iff (rst_all)
    (wr_dram && REG_WDATA == ebdram_pkg::CTL_IGNORE_1W) |=>
      (DRAM_SPACE == ebdram_pkg::SPACE_IGNORED && DRAM_WAIT && !SELF_REFRESH
       && !in_dram(BUS_ADDR, DRAM_SPACE)))
    else $error("ignore setting not applied");

  AST_CTL_4MB: assert property (@(posedge SYS_CLK) disable iff (rst_all)
    (wr_dram && REG_WDATA == ebdram_pkg::CTL_4MB_1W) |=>
      (DRAM_SPACE == ebdram_pkg::SPACE_4MB && DRAM_WAIT && !SELF_REFRESH
       && in_dram(24'hC00000, DRAM_SPACE) && !in_dram(24'hBFFFFF, DRAM_SPACE)))
    else $error("4 MB setting not applied");

  AST_SR_NO_GRANT: assert property (@(posedge SYS_CLK) disable iff (rst_all)
    SELF_REFRESH |-> !BUS_GRANT)
    else $error("grant during self-refresh");

  AST_LP_FREEZE: assert property (@(posedge SYS_CLK) disable iff (rst_all)
    (lp_active && $past(lp_active) && ext_mode) |-> ##1 $stable(P4_OUT))
    else $error("bus pin moved in low power");

  AST_PORT_IGNORED: assert property (@(posedge SYS_CLK) disable iff (rst_all)
    (REG_WR && ext_mode && REG_ADDR == ebdram_pkg::OFF_P4_DIR) |=> $stable(p4_dir))
    else $error("port write took effect in bus mode");

  AST_ROM_LOCK: assert property (@(posedge SYS_CLK) disable iff (RESET)
    rom_lock |-> !ROM_RD_GRANT)
    else $error("rom readout while locked");
endmodule

//--- tb/ebdram_mem.sv
// bus-side memory model resolving port pins and watching strobes
`timescale 1ns/1ps
module ebdram_mem (
  input  wire logic       clk,
  input  wire logic       sr,
  input  wire logic [7:0] a_out,
  input  wire logic [7:0] a_oe,
  input  wire logic [2:0] s_out,
  input  wire logic [2:0] s_oe,
  output logic      [7:0] a_in,
  output logic      [2:0] s_in,
  output int              bad_acc
);
  logic [7:0] a_last;
  logic [2:0] s_last;
  initial begin
    a_last = 8'h00;
    s_last = 3'h7;
    bad_acc = 0;
  end
  // released pins show inverse of last level
  assign a_in = (a_out & a_oe) | (~a_last & ~a_oe);
  assign s_in = (s_out & s_oe) | (~s_last & ~s_oe);
  // unknown levels before reset are not remembered
  always @(posedge clk) begin
    if (!$isunknown(a_in))
      a_last <= a_in;
    if (!$isunknown(s_in))
      s_last <= s_in;
  end
  always @(posedge clk) begin
    if (sr && ((s_oe & ~s_out) != 3'h0))
      bad_acc <= bad_acc + 1;
  end
endmodule

//--- tb/tb.sv
// self-checking bench for the external bus and dram control block
`timescale 1ns/1ps
module tb;
  logic        SYS_CLK, RESET, REG_WR, REG_RD, BUS_REQ, BUS_WE, BUS_GRANT, BUS_DRAM_SEL;
  logic        WAKE, HOLD_N, BOOT_MODE_PIN, ROM_RD_REQ, ROM_RD_GRANT;
  logic        DRAM_WAIT, SELF_REFRESH, SW_RESET, LOW_POWER;
  logic [3:0]  REG_ADDR;
  logic [7:0]  REG_WDATA, REG_RDATA, P4_IN, P4_OUT, P4_OE;
  logic [23:0] BUS_ADDR;
  logic [2:0]  DRAM_SPACE, P5_IN, P5_OUT, P5_OE;
  int          errors, compares, bad_acc;

  ebdram_top #(.ADDR_W(24)) dut_u (.SYS_CLK(SYS_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .BUS_REQ(BUS_REQ), .BUS_WE(BUS_WE), .BUS_ADDR(BUS_ADDR), .BUS_GRANT(BUS_GRANT),
    .BUS_DRAM_SEL(BUS_DRAM_SEL), .WAKE(WAKE), .HOLD_N(HOLD_N), .BOOT_MODE_PIN(BOOT_MODE_PIN),
    .ROM_RD_REQ(ROM_RD_REQ), .ROM_RD_GRANT(ROM_RD_GRANT), .DRAM_SPACE(DRAM_SPACE),
    .DRAM_WAIT(DRAM_WAIT), .SELF_REFRESH(SELF_REFRESH), .SW_RESET(SW_RESET),
    .LOW_POWER(LOW_POWER), .P4_IN(P4_IN), .P4_OUT(P4_OUT), .P4_OE(P4_OE), .P5_IN(P5_IN),
    .P5_OUT(P5_OUT), .P5_OE(P5_OE));

  ebdram_mem mem_u (.clk(SYS_CLK), .sr(SELF_REFRESH), .a_out(P4_OUT), .a_oe(P4_OE),
    .s_out(P5_OUT), .s_oe(P5_OE), .a_in(P4_IN), .s_in(P5_IN), .bad_acc(bad_acc));

  initial begin
    SYS_CLK = 1'b0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end

  function automatic logic exp_sel(input logic [23:0] a, input logic [2:0] sp);
    if (sp == ebdram_pkg::SPACE_IGNORED)
      return 1'b0;
    return (a >> (sp + 17)) == (24'hFFFFFF >> (sp + 17));
  endfunction

  task automatic chk(input string nm, input logic [23:0] ex, input logic [23:0] got);
    compares++;
    if (got !== ex) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic test_done;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
    @(posedge SYS_CLK);
  endtask

  task automatic rc(input string nm, input logic [3:0] a, input logic [7:0] m,
                    input logic [7:0] ex);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1 chk(nm, ex, REG_RDATA & m);
    @(posedge SYS_CLK);
  endtask

  task automatic ctl(input logic [2:0] sp, input logic w, input logic sr);
    #1 chk("space", sp, DRAM_SPACE);
    chk("wait", w, DRAM_WAIT);
    chk("sref", sr, SELF_REFRESH);
    @(posedge SYS_CLK);
  endtask

  task automatic bus(input logic [23:0] a, input logic g, input logic s);
    BUS_REQ <= 1'b1;
    BUS_WE <= a[0];
    BUS_ADDR <= a;
    #1 chk("grant", g, BUS_GRANT);
    if (g)
      chk("dram_sel", s, BUS_DRAM_SEL);
    @(posedge SYS_CLK);
  endtask

  task automatic idle(input int n);
    BUS_REQ <= 1'b0;
    repeat (n) @(posedge SYS_CLK);
  endtask

  task automatic mode(input logic [7:0] v);
    wr(ebdram_pkg::OFF_WPROT, 8'h02);
    wr(ebdram_pkg::OFF_PROC_MODE0, v);
  endtask

  task automatic hold_chk(input logic [7:0] ex);
    mode({6'h00, ebdram_pkg::MODE_MEMEXP});
    HOLD_N <= 1'b0;
    idle(5);
    #1 chk("p4_oe_hold", ex, P4_OE);
    @(posedge SYS_CLK);
    bus(24'h123456, 1'b0, 1'b0);
    HOLD_N <= 1'b1;
    idle(4);
  endtask

  initial begin
    logic [23:0] a;
    logic        seen;
    int          k;
    errors = 0;
    compares = 0;
    {RESET, HOLD_N, ROM_RD_REQ} = 3'h7;
    {REG_WR, REG_RD, BUS_REQ, BUS_WE, WAKE, BOOT_MODE_PIN} = 6'h00;
    REG_ADDR = 4'h0;
    REG_WDATA = 8'h00;
    BUS_ADDR = 24'h000000;
    k = $urandom(71);
    repeat (10) @(posedge SYS_CLK);
    RESET <= 1'b0;
    @(posedge SYS_CLK);
    rc("ctl", ebdram_pkg::OFF_DRAM_CTL, 8'hFF, ebdram_pkg::RST_DRAM_CTL);
    chk("rom_open", 1'b1, ROM_RD_GRANT);
    wr(ebdram_pkg::OFF_P4_DATA, 8'hA5);
    wr(ebdram_pkg::OFF_P4_DIR, 8'hFF);
    idle(2);
    #1 chk("p4_out", 8'hA5, P4_OUT);
    hold_chk(8'hFF);
    wr(ebdram_pkg::OFF_P4_DATA, 8'h3C);
    wr(ebdram_pkg::OFF_P4_DIR, 8'h0F);
    wr(ebdram_pkg::OFF_DRAM_CTL, ebdram_pkg::CTL_IGNORE_1W);
    ctl(ebdram_pkg::SPACE_IGNORED, 1'b1, 1'b0);
    for (k = 0; k < 16; k++)
      bus(24'($urandom), 1'b1, 1'b0);
    idle(1);
    wr(ebdram_pkg::OFF_DRAM_CTL, ebdram_pkg::CTL_IGNORE_1W);
    wr(ebdram_pkg::OFF_DRAM_CTL, 8'h8B);
    ctl(ebdram_pkg::SPACE_4MB, 1'b1, 1'b1);
    idle(2);
    for (k = 0; k < 8; k++)
      bus(24'($urandom), 1'b0, 1'b0);
    idle(1);
    rc("seq_ok", ebdram_pkg::OFF_STATUS, 8'h05, 8'h01);
    chk("sr_strobes", 24'h000000, 24'(bad_acc));
    wr(ebdram_pkg::OFF_DRAM_CTL, ebdram_pkg::CTL_IGNORE_1W);
    ctl(ebdram_pkg::SPACE_IGNORED, 1'b1, 1'b0);
    wr(ebdram_pkg::OFF_DRAM_CTL, ebdram_pkg::CTL_4MB_1W);
    // no dram access straight after space write
    idle(1);
    ctl(ebdram_pkg::SPACE_4MB, 1'b1, 1'b0);
    bus(24'hC00000, 1'b1, 1'b1);
    bus(24'hBFFFFF, 1'b1, 1'b0);
    for (k = 0; k < 24; k++) begin
      a = 24'($urandom);
      bus(a, 1'b1, exp_sel(a, ebdram_pkg::SPACE_4MB));
    end
    idle(1);
    wr(ebdram_pkg::OFF_DRAM_CTL, 8'h8B);
    rc("seq_err", ebdram_pkg::OFF_STATUS, 8'h04, 8'h04);
    wr(ebdram_pkg::OFF_DRAM_CTL, ebdram_pkg::CTL_IGNORE_1W);
    wr(ebdram_pkg::OFF_STATUS, 8'h04);
    rc("seq_clr", ebdram_pkg::OFF_STATUS, 8'h04, 8'h00);
    for (k = 0; k < 2; k++) begin
      bus(24'h5A0000, 1'b1, 1'b0);
      idle(2);
      wr(ebdram_pkg::OFF_LOW_POWER, 8'h01 << k);
      repeat (6) begin
        #1 chk("bus_keep", 8'h5A, P4_OUT);
        bus(24'($urandom), 1'b0, 1'b0);
      end
      WAKE <= 1'b1;
      idle(1);
      WAKE <= 1'b0;
      idle(2);
      #1 chk("awake", 1'b0, LOW_POWER);
      @(posedge SYS_CLK);
    end
    mode({6'h00, ebdram_pkg::MODE_SINGLE});
    idle(3);
    #1 chk("p4_single", 8'hA5, P4_OUT);
    chk("p4_dir_single", 8'hFF, P4_OE);
    @(posedge SYS_CLK);
    wr(ebdram_pkg::OFF_P4_DIR, 8'h00);
    // pins made inputs before the switch
    hold_chk(8'h00);
    wr(ebdram_pkg::OFF_WPROT, 8'h02);
    REG_WR <= 1'b1;
    REG_ADDR <= ebdram_pkg::OFF_PROC_MODE0;
    REG_WDATA <= 8'h09;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
    seen = 1'b0;
    for (k = 0; k < 4; k++) begin
      #1 seen = seen | (SW_RESET === 1'b1);
      @(posedge SYS_CLK);
    end
    chk("sw_reset", 1'b1, seen);
    idle(3);
    rc("ctl_swrst", ebdram_pkg::OFF_DRAM_CTL, 8'hFF, 8'h00);
    RESET <= 1'b1;
    BOOT_MODE_PIN <= 1'b1;
    repeat (10) @(posedge SYS_CLK);
    RESET <= 1'b0;
    idle(2);
    #1 chk("rom_lock", 1'b0, ROM_RD_GRANT);
    @(posedge SYS_CLK);
    rc("rom_stat", ebdram_pkg::OFF_STATUS, 8'h08, 8'h08);
    bus(24'($urandom), 1'b1, 1'b0);
    idle(1);
    test_done();
  end
endmodule
